// ---- logic/lmd_unit.sv ----
/*
  descending block-load execute unit with an axi4-lite register slave.
  assumes a memory port that answers each held word request with a
  one-cycle ack, and a register file that takes one write per cycle.
*/
// Notes on behaviour
// - words end just below base address
// - writeback stores lowest address when enabled
// - lowest register gets lowest address word
// - program counter load acts as branch
// - even branch target raises misuse fault
// - mask is pc, lr, zero, low bits
// - bad base, short list, pc+lr unpredictable
// - pc load mid conditional block unpredictable
// - writeback with base in list unpredictable
// - failed condition makes no access, only raises done event
`timescale 1ns/10ps
`default_nettype none
module lmd_unit #(
  parameter int AW = 8
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [AW-1:0]        s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [AW-1:0]        s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      mem_req,
  output logic [31:0]               mem_addr,
  input  wire lmd_pkg::lmd_mem_rsp_t mem_rsp,
  output logic                      rf_we,
  output logic [3:0]                rf_idx,
  output logic [31:0]               rf_data,
  output logic                      br_valid,
  output logic [31:0]               br_target,
  output logic                      fault_valid,
  output lmd_pkg::lmd_fault_t       fault_kind,
  output logic                      irq
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  lmd_pkg::lmd_state_t state_reg;
  lmd_pkg::lmd_dec_t   dec;
  logic [31:0]         instr_reg;
  logic [31:0]         base_reg;
  logic [2:0]          flags_reg;
  logic [5:0]          ev_stat_reg;
  logic [5:0]          ev_mask_reg;
  logic [5:0]          ev_set;
  logic [5:0]          ev_clr;
  logic                go_reg;
  logic                aw_got_reg;
  logic                w_got_reg;
  logic [AW-1:0]       aw_addr_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                wr_do;
  logic [7:0]          wr_off;
  logic [7:0]          rd_off;
  logic [15:0]         remain_reg;
  logic [31:0]         addr_reg;
  logic [31:0]         low_addr_reg;
  logic [3:0]          cur_idx_reg;
  logic                pc_hit_reg;
  logic [31:0]         pc_word_reg;
  logic [3:0]          next_idx;
  logic                any_left;
  logic [15:0]         remain_after;
  logic                beat_ok;
  logic [31:0]         start_addr;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  lmd_decode u_dec (
    .instr    (instr_reg),
    .in_blk   (flags_reg[lmd_pkg::FLG_INBLK_BIT]),
    .last_blk (flags_reg[lmd_pkg::FLG_LAST_BIT]),
    .dec      (dec)
  );

  lmd_lowest #(.W(16), .IW(4)) u_low (
    .vec   (remain_reg),
    .idx   (next_idx),
    .found (any_left)
  );

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  // address and data may arrive in either order; both are held
  assign wr_do  = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wr_off = 8'(aw_addr_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lmd_pkg::RESP_OKAY;
      aw_addr_reg   <= '0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg    <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_got_reg && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg    <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (!w_got_reg && !s_axi_bvalid)
      begin
        s_axi_wready <= 1'b1;
      end
      if (wr_do)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_off > lmd_pkg::OFF_BRANCH || wr_off[1:0] != 2'h0)
                        ? lmd_pkg::RESP_SLVERR : lmd_pkg::RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // a go while busy is dropped; the instruction fields must not move
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      instr_reg   <= lmd_pkg::INSTR_RST;
      base_reg    <= lmd_pkg::BASE_RST;
      flags_reg   <= lmd_pkg::FLAGS_RST;
      ev_mask_reg <= lmd_pkg::EV_MASK_RST;
      go_reg      <= 1'b0;
    end
    else
    begin
      go_reg <= wr_do && wr_off == lmd_pkg::OFF_CTRL && w_strb_reg[0]
                && w_data_reg[lmd_pkg::CTRL_GO_BIT] && state_reg == lmd_pkg::ST_IDLE;
      if (wr_do && state_reg == lmd_pkg::ST_IDLE)
      begin
        case (wr_off)
          lmd_pkg::OFF_INSTR: instr_reg <= merge(instr_reg, w_data_reg, w_strb_reg);
          lmd_pkg::OFF_BASE:  base_reg  <= merge(base_reg, w_data_reg, w_strb_reg);
          lmd_pkg::OFF_FLAGS:
          begin
            if (w_strb_reg[0])
            begin
              flags_reg <= w_data_reg[2:0];
            end
          end
          default: ;
        endcase
      end
      if (wr_do && wr_off == lmd_pkg::OFF_EV_MASK && w_strb_reg[0])
      begin
        ev_mask_reg <= w_data_reg[5:0];
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  assign rd_off = 8'(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lmd_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= lmd_pkg::RESP_OKAY;
      case (rd_off)
        lmd_pkg::OFF_CTRL:    s_axi_rdata <= 32'h0000_0000;
        lmd_pkg::OFF_INSTR:   s_axi_rdata <= instr_reg;
        lmd_pkg::OFF_BASE:    s_axi_rdata <= base_reg;
        lmd_pkg::OFF_FLAGS:   s_axi_rdata <= {29'h0, flags_reg};
        lmd_pkg::OFF_STATUS:  s_axi_rdata <= {23'h0, dec.cnt, 1'b0, dec.unpred,
                                              dec.recognised, state_reg != lmd_pkg::ST_IDLE};
        lmd_pkg::OFF_EV_STAT: s_axi_rdata <= {26'h0, ev_stat_reg};
        lmd_pkg::OFF_EV_MASK: s_axi_rdata <= {26'h0, ev_mask_reg};
        lmd_pkg::OFF_BRANCH:  s_axi_rdata <= pc_word_reg;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= lmd_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------
  assign beat_ok = state_reg == lmd_pkg::ST_WAIT && mem_rsp.ack
                   && mem_rsp.err == lmd_pkg::FLT_NONE;
  assign ev_clr  = (wr_do && wr_off == lmd_pkg::OFF_EV_STAT && w_strb_reg[0])
                   ? w_data_reg[5:0] : 6'h00;

  always_comb
  begin
    ev_set = 6'h00;
    if (go_reg && state_reg == lmd_pkg::ST_IDLE)
    begin
      ev_set[lmd_pkg::EV_NOTREC] = !dec.recognised;
      ev_set[lmd_pkg::EV_UNPRED] = dec.recognised && dec.unpred;
      ev_set[lmd_pkg::EV_DONE]   = dec.recognised && !dec.unpred
                                   && !flags_reg[lmd_pkg::FLG_COND_BIT];
    end
    if (state_reg == lmd_pkg::ST_WAIT && mem_rsp.ack)
    begin
      ev_set[lmd_pkg::EV_PROT] = mem_rsp.err == lmd_pkg::FLT_PROT;
      ev_set[lmd_pkg::EV_BUS]  = mem_rsp.err == lmd_pkg::FLT_BUS;
    end
    ev_set[lmd_pkg::EV_MISUSE] = beat_ok && cur_idx_reg == lmd_pkg::PC_IDX
                                 && !mem_rsp.rdata[0];
    if (state_reg == lmd_pkg::ST_DONE)
    begin
      ev_set[lmd_pkg::EV_DONE] = 1'b1;
    end
  end

  // set beats clear when both land in one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_stat_reg <= 6'h00;
      irq         <= 1'b0;
    end
    else
    begin
      ev_stat_reg <= (ev_stat_reg & ~ev_clr) | ev_set;
      irq         <= |(((ev_stat_reg & ~ev_clr) | ev_set) & ev_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // load sequencer
  // ------------------------------------------------------------
  assign start_addr   = base_reg - {25'h0, dec.cnt, 2'h0};
  assign remain_after = remain_reg & ~(16'h0001 << cur_idx_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= lmd_pkg::ST_IDLE;
      remain_reg   <= 16'h0000;
      addr_reg     <= 32'h0000_0000;
      low_addr_reg <= 32'h0000_0000;
      cur_idx_reg  <= 4'h0;
      pc_hit_reg   <= 1'b0;
      pc_word_reg  <= 32'h0000_0000;
      mem_req      <= 1'b0;
      mem_addr     <= 32'h0000_0000;
      rf_we        <= 1'b0;
      rf_idx       <= 4'h0;
      rf_data      <= 32'h0000_0000;
      br_valid     <= 1'b0;
      br_target    <= 32'h0000_0000;
      fault_valid  <= 1'b0;
      fault_kind   <= lmd_pkg::FLT_NONE;
    end
    else
    begin
      rf_we       <= 1'b0;
      br_valid    <= 1'b0;
      fault_valid <= 1'b0;
      case (state_reg)
        lmd_pkg::ST_IDLE:
        begin
          // undecodable, unpredictable or failed-condition: no access at all
          if (go_reg && dec.recognised && !dec.unpred
              && flags_reg[lmd_pkg::FLG_COND_BIT])
          begin
            remain_reg   <= dec.mask;
            addr_reg     <= start_addr;
            low_addr_reg <= start_addr;
            pc_hit_reg   <= 1'b0;
            state_reg    <= lmd_pkg::ST_ISSUE;
          end
        end
        lmd_pkg::ST_ISSUE:
        begin
          mem_req     <= 1'b1;
          mem_addr    <= addr_reg;
          cur_idx_reg <= next_idx;
          state_reg   <= lmd_pkg::ST_WAIT;
        end
        lmd_pkg::ST_WAIT:
        begin
          if (mem_rsp.ack)
          begin
            mem_req <= 1'b0;
            if (mem_rsp.err != lmd_pkg::FLT_NONE)
            begin
              // abandon the sequence: no writeback after a faulted word
              fault_valid <= 1'b1;
              fault_kind  <= mem_rsp.err;
              state_reg   <= lmd_pkg::ST_IDLE;
            end
            else if (cur_idx_reg == lmd_pkg::PC_IDX && !mem_rsp.rdata[0])
            begin
              fault_valid <= 1'b1;
              fault_kind  <= lmd_pkg::FLT_MISUSE;
              state_reg   <= lmd_pkg::ST_IDLE;
            end
            else
            begin
              if (cur_idx_reg == lmd_pkg::PC_IDX)
              begin
                pc_hit_reg  <= 1'b1;
                pc_word_reg <= mem_rsp.rdata;
              end
              else
              begin
                rf_we   <= 1'b1;
                rf_idx  <= cur_idx_reg;
                rf_data <= mem_rsp.rdata;
              end
              remain_reg <= remain_after;
              addr_reg   <= addr_reg + lmd_pkg::WORD_BYTES;
              state_reg  <= (remain_after == 16'h0000) ? lmd_pkg::ST_DONE
                                                        : lmd_pkg::ST_ISSUE;
            end
          end
        end
        lmd_pkg::ST_DONE:
        begin
          if (dec.wback)
          begin
            rf_we   <= 1'b1;
            rf_idx  <= dec.rn;
            rf_data <= low_addr_reg;
          end
          br_valid  <= pc_hit_reg;
          br_target <= pc_word_reg;
          state_reg <= lmd_pkg::ST_IDLE;
        end
        default: state_reg <= lmd_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_quiet;
    !mem_req && !rf_we && !br_valid [*3];
  endsequence

  sequence seq_exec_go;
    go_reg && state_reg == lmd_pkg::ST_IDLE && dec.recognised && !dec.unpred
    && flags_reg[lmd_pkg::FLG_COND_BIT];
  endsequence

  AST_FIRST_ADDR: assert property (seq_exec_go |-> ##2 mem_req && mem_addr == $past(start_addr, 2))
    else $error("first word not at base minus four per register");
  AST_WBACK: assert property (state_reg == lmd_pkg::ST_DONE && dec.wback
                              |=> rf_we && rf_idx == dec.rn && rf_data == low_addr_reg)
    else $error("writeback missing or wrong");
  AST_NO_WBACK: assert property (state_reg == lmd_pkg::ST_DONE && !dec.wback |=> !rf_we)
    else $error("base written without writeback");
  AST_ASCEND: assert property (beat_ok && remain_after != 16'h0000
                               |=> ##1 mem_req && mem_addr == $past(mem_addr, 2) + 32'h4)
    else $error("next word not four bytes higher");
  AST_BRANCH_ODD: assert property (br_valid |-> br_target[0] && $past(state_reg) == lmd_pkg::ST_DONE)
    else $error("branch with even target or out of sequence");
  AST_MISUSE: assert property (beat_ok && cur_idx_reg == lmd_pkg::PC_IDX && !mem_rsp.rdata[0]
                               |=> fault_valid && fault_kind == lmd_pkg::FLT_MISUSE ##1 seq_quiet)
    else $error("even program counter word did not fault");
  AST_LOW_ZERO: assert property (dec.mask[lmd_pkg::ZERO_BIT] == 1'b0)
    else $error("forced zero position set in mask");
  AST_UNPRED: assert property (go_reg && state_reg == lmd_pkg::ST_IDLE && dec.unpred
                               |=> state_reg == lmd_pkg::ST_IDLE ##0 seq_quiet)
    else $error("unpredictable form executed");
  AST_MID_BLOCK: assert property (dec.mask[15] && flags_reg[lmd_pkg::FLG_INBLK_BIT]
                                  && !flags_reg[lmd_pkg::FLG_LAST_BIT] |-> dec.unpred)
    else $error("mid-block program counter load not flagged");
  AST_BASE_LISTED: assert property (dec.wback && dec.mask[dec.rn] |-> dec.unpred)
    else $error("writeback with listed base not flagged");
  AST_NOT_REC: assert property (go_reg && state_reg == lmd_pkg::ST_IDLE && !dec.recognised
                                |=> ev_stat_reg[lmd_pkg::EV_NOTREC] ##0 seq_quiet)
    else $error("foreign encoding executed");
  AST_MEM_FAULT: assert property (state_reg == lmd_pkg::ST_WAIT && mem_rsp.ack
                                  && mem_rsp.err != lmd_pkg::FLT_NONE
                                  |=> fault_valid && fault_kind == $past(mem_rsp.err) && !rf_we)
    else $error("memory fault not reported");
  AST_COND_FAIL: assert property (go_reg && state_reg == lmd_pkg::ST_IDLE && dec.recognised
                                  && !dec.unpred && !flags_reg[lmd_pkg::FLG_COND_BIT]
                                  |=> seq_quiet)
    else $error("failed condition still acted");
endmodule // lmd_unit
`default_nettype wire

// ---- logic/lmd_pkg.sv ----
/*
  shared constants and types of the descending block-load unit:
  register map, field positions, reset values, state and fault encodings.
  assumes a 32-bit data path and an 8-bit register bus address.
*/
`default_nettype none
package lmd_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_INSTR   = 8'h04;
  localparam logic [7:0] OFF_BASE    = 8'h08;
  localparam logic [7:0] OFF_FLAGS   = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_EV_STAT = 8'h14;
  localparam logic [7:0] OFF_EV_MASK = 8'h18;
  localparam logic [7:0] OFF_BRANCH  = 8'h1c;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_GO_BIT   = 0;
  localparam int FLG_COND_BIT  = 0;
  localparam int FLG_INBLK_BIT = 1;
  localparam int FLG_LAST_BIT  = 2;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_REC_BIT    = 1;
  localparam int ST_UNPRED_BIT = 2;
  localparam int ST_CNT_LSB    = 4;
  localparam int EV_DONE       = 0;
  localparam int EV_UNPRED     = 1;
  localparam int EV_MISUSE     = 2;
  localparam int EV_PROT       = 3;
  localparam int EV_BUS        = 4;
  localparam int EV_NOTREC     = 5;
  localparam int EV_W          = 6;
  // ------------------------------------------------------------
  // reset values and encodings
  // ------------------------------------------------------------
  localparam logic [31:0] INSTR_RST   = 32'h0000_0000;
  localparam logic [31:0] BASE_RST    = 32'h0000_0000;
  localparam logic [2:0]  FLAGS_RST   = 3'h1;
  localparam logic [5:0]  EV_MASK_RST = 6'h00;
  localparam logic [9:0]  OPC_HI      = 10'h3a4;
  localparam logic [3:0]  PC_IDX      = 4'hf;
  localparam int          ZERO_BIT    = 13;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT  = 2'h3,
    ST_DONE  = 2'h2
  } lmd_state_t;

  typedef enum logic [1:0] {
    FLT_NONE   = 2'h0,
    FLT_PROT   = 2'h1,
    FLT_BUS    = 2'h2,
    FLT_MISUSE = 2'h3
  } lmd_fault_t;

  typedef struct packed {
    logic        recognised;
    logic        wback;
    logic [3:0]  rn;
    logic [15:0] mask;
    logic [4:0]  cnt;
    logic        unpred;
  } lmd_dec_t;

  typedef struct packed {
    logic        ack;
    lmd_fault_t  err;
    logic [31:0] rdata;
  } lmd_mem_rsp_t;
endpackage
`default_nettype wire

// ---- logic/lmd_lowest.sv ----
/*
  finds the lowest set bit of a vector.
  assumes nothing of its surroundings; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module lmd_lowest #(
  parameter int W  = 16,
  parameter int IW = 4
) (
  input  wire logic [W-1:0]  vec,
  output logic      [IW-1:0] idx,
  output logic               found
);
  // scan from the top so the lowest set bit is the last one written
  always_comb
  begin
    idx   = '0;
    found = 1'b0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (vec[i])
      begin
        idx   = IW'(i);
        found = 1'b1;
      end
    end
  end
endmodule // lmd_lowest
`default_nettype wire

// ---- logic/lmd_decode.sv ----
/*
  decodes the 32-bit descending block-load encoding.
  assumes first halfword in bits 31:16, second in bits 15:0.
*/
`timescale 1ns/10ps
`default_nettype none
module lmd_decode (
  input  wire logic [31:0]    instr,
  input  wire logic           in_blk,
  input  wire logic           last_blk,
  output lmd_pkg::lmd_dec_t   dec
);
  logic [15:0] hw1;
  logic [15:0] hw2;
  logic [15:0] mask;
  logic [4:0]  cnt;

  assign hw1 = instr[31:16];
  assign hw2 = instr[15:0];
  // bit 13 forced low, so the stack pointer never lands in the list
  assign mask = {hw2[15], hw2[14], 1'b0, hw2[12:0]};

  always_comb
  begin
    cnt = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      cnt = cnt + {4'h0, mask[i]};
    end
  end

  always_comb
  begin
    dec.recognised = (hw1[15:6] == lmd_pkg::OPC_HI) && hw1[4];
    dec.wback      = hw1[5];
    dec.rn         = hw1[3:0];
    dec.mask       = mask;
    dec.cnt        = cnt;
    dec.unpred     = (hw1[3:0] == lmd_pkg::PC_IDX) || (cnt < 5'h02)
                     || (hw2[15] && hw2[14])
                     || (mask[15] && in_blk && !last_blk)
                     || (hw1[5] && mask[hw1[3:0]]);
  end
endmodule // lmd_decode
`default_nettype wire

// ---- bench/lmd_mem_model.sv ----
/*
  memory model answering word loads, promptly or slowly.
  assumes one held request at a time and a one-cycle ack.
*/
`timescale 1ns/10ps
`default_nettype none
module lmd_mem_model (
  input  wire logic                aclk,
  input  wire logic                req,
  input  wire logic [31:0]         addr,
  input  wire logic                slow,
  input  wire logic                even,
  input  wire lmd_pkg::lmd_fault_t flt,
  output lmd_pkg::lmd_mem_rsp_t    rsp
);
  logic [1:0] dly_reg = 2'h0;
  initial rsp = '0;
  // idle data toggles so a stale word never passes for a fresh one
  always @(posedge aclk)
  begin
    rsp.ack <= 1'b0;
    rsp.rdata <= ~rsp.rdata;
    dly_reg <= slow ? dly_reg + 2'h1 : 2'h3;
    if (req && !rsp.ack && dly_reg == 2'h3)
    begin
      rsp.ack <= 1'b1;
      rsp.err <= flt;
      rsp.rdata <= {addr[31:1], ~even};
    end
  end
endmodule // lmd_mem_model
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  bench for the block-load unit: axi4-lite tasks and an output queue.
  assumes the memory model as the far side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic slow = 0, even = 0, awr, wr_r, bv, arr, rv, mreq, we, brv, fv, irq;
  logic [7:0] awa = 0, ara = 0;
  logic [9:0] opx = 0;
  logic [31:0] wd = 0, a, rdat, maddr, rfd, brt;
  logic [33:0] rd_d;
  logic [5:0] msk = 0, ev;
  logic [1:0] bresp, rresp;
  logic [3:0] rfi;
  lmd_pkg::lmd_fault_t flt = lmd_pkg::FLT_NONE, fk;
  lmd_pkg::lmd_mem_rsp_t rsp;
  logic [37:0] q[$];
  int fails = 0, cmp_count = 0;
  always #10 aclk = ~aclk;
  lmd_unit u_lmd_unit (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .mem_req(mreq),
    .mem_addr(maddr), .mem_rsp(rsp), .rf_we(we), .rf_idx(rfi), .rf_data(rfd),
    .br_valid(brv), .br_target(brt), .fault_valid(fv), .fault_kind(fk), .irq(irq));
  lmd_mem_model u_lmd_mem_model (.aclk(aclk), .req(mreq), .addr(maddr), .slow(slow),
    .even(even), .flt(flt), .rsp(rsp));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [37:0] s, input logic [37:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    {awa, wd, awv, wv, bre} <= {ad, d, 3'b111};
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
    end
    while (!bv);
    bre <= 0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge aclk);
    {ara, arv, rre} <= {ad, 2'b11};
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end
    while (!rv);
    rd_d = {rresp, rdat};
    rre <= 0;
  endtask
  // loads are noted only when they must happen; a failed run leaves the queue idle
  task automatic run(input logic w, input logic [3:0] rn, input logic [15:0] m,
    input logic [2:0] fl, input logic [5:0] e);
    logic [31:0] b;
    b = {16'h0, 14'($urandom), 2'h0} + 32'h40;
    a = b - 32'(4 * $countones(m & 16'hdfff));
    wr(lmd_pkg::OFF_INSTR, {lmd_pkg::OPC_HI ^ opx, w, 1'b1, rn, m});
    wr(lmd_pkg::OFF_BASE, b);
    wr(lmd_pkg::OFF_FLAGS, {29'h0, fl});
    if (w && e[0]) b = a;
    if (flt != lmd_pkg::FLT_NONE) q.push_back({6'h20, 30'h0, flt});
    else if (!e[1] && !e[5] && fl[0])
      for (int i = 0; i < 16; i++)
        if (m[i] && i != 13)
        begin
          q.push_back(i < 15 ? {2'h0, 4'(i), a[31:1], ~even}
            : even ? {6'h20, 32'h3} : {6'h1f, a[31:1], 1'b1});
          a += 4;
        end
    if (w && e[0]) q.push_back({2'h0, rn, b});
    wr(lmd_pkg::OFF_CTRL, 32'h1);
    ev = 0;
    for (int k = 0; k < 40 && ev == 0; k++)
    begin
      rd(lmd_pkg::OFF_EV_STAT);
      ev = rd_d[5:0];
    end
    repeat (4) @(posedge aclk);
    rd(lmd_pkg::OFF_EV_STAT);
    chk("ev", rd_d[5:0] & (e[0] ? 6'h3f : 6'h3e), e);
    chk("irq", irq, |(rd_d[5:0] & msk));
    wr(lmd_pkg::OFF_EV_STAT, 32'h3f);
    repeat (2) @(posedge aclk);
    chk("irq0", irq, 0);
    chk("left", q.size(), 0);
  endtask
  task automatic pop(input logic [37:0] s);
    chk("out", s, q.size() ? q.pop_front() : ~s);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge aclk)
  begin
    if (fv) pop({6'h20, 30'h0, fk});
    if (brv) pop({6'h1f, brt});
    if (we) pop({2'h0, rfi, rfd});
  end
  initial
  begin
    repeat (30000) @(posedge aclk);
    fails++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(4001));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    msk = 6'h01;
    wr(lmd_pkg::OFF_EV_MASK, 32'h1);
    run(1, 4'h3, 16'h0003, 3'h1, 6'h01);
    msk = 6'h00;
    wr(lmd_pkg::OFF_EV_MASK, 32'h0);
    slow = 1;
    run(0, 4'hd, 16'ha024, 3'h5, 6'h01);
    even = 1;
    run(0, 4'h4, 16'h8001, 3'h1, 6'h04);
    {even, flt} = {1'b0, lmd_pkg::FLT_PROT};
    run(1, 4'h1, 16'h0030, 3'h1, 6'h08);
    flt = lmd_pkg::FLT_BUS;
    run(1, 4'h1, 16'h0030, 3'h1, 6'h10);
    flt = lmd_pkg::FLT_NONE;
    run(0, 4'hf, 16'h0003, 3'h1, 6'h02);
    run(0, 4'h1, 16'h0004, 3'h1, 6'h02);
    run(0, 4'h1, 16'hc001, 3'h1, 6'h02);
    run(0, 4'h1, 16'h8001, 3'h3, 6'h02);
    run(1, 4'h2, 16'h0006, 3'h1, 6'h02);
    run(1, 4'h5, 16'h0006, 3'h0, 6'h00);
    opx = 10'h001;
    run(0, 4'h1, 16'h0003, 3'h1, 6'h20);
    rd(8'h20);
    chk("unmapped", rd_d, {2'h2, 32'h0});
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
